//--- rtl/acl_action_pkg.sv
// constants for the per-port priority and remark action bytes
// assumes one byte-wide register port and ports numbered 1 to 5
package acl_action_pkg;

	// register port addresses
	localparam logic [7:0] ADDR_IND_CTRL = 8'h6e;
	localparam logic [7:0] ADDR_IND_OFFS = 8'h6f;
	localparam logic [7:0] ADDR_IND_DATA = 8'ha0;

	// indirect control fields
	localparam int          TBL_SEL_MSB  = 7;
	localparam int          TBL_SEL_LSB  = 5;
	localparam int          PORT_SEL_MSB = 3;
	localparam int          PORT_SEL_LSB = 0;
	localparam logic [2:0] TBL_ACL      = 3'h2;
	localparam logic [3:0] PORT_FIRST   = 4'h1;
	localparam logic [3:0] PORT_LAST    = 4'h5;
	localparam int          NUM_PORTS    = 5;

	// byte offsets inside an entry
	localparam logic [7:0] OFF_PRI_ACTION = 8'h0a;
	localparam logic [7:0] OFF_REMARK_MAP = 8'h0b;

	// priority action byte fields
	localparam int MODE_MSB   = 7;
	localparam int MODE_LSB   = 6;
	localparam int PRI_MSB    = 5;
	localparam int PRI_LSB    = 3;
	localparam int RPE_BIT    = 2;
	localparam int RP_HI_MSB  = 1;
	localparam int RP_HI_LSB  = 0;
	// remark map byte field
	localparam int RP_LO_BIT  = 7;

	// stored entry: {mode[1:0], pri[2:0], rpe, rp_hi[1:0], rp_lo}
	localparam int          ENTRY_W     = 9;
	localparam logic [8:0] ENTRY_RESET = 9'h000;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] OFFS_RESET  = 8'h00;

	typedef enum logic [1:0] {
		MODE_NONE    = 2'b00,
		MODE_GREATER = 2'b01,
		MODE_SMALLER = 2'b10,
		MODE_REPLACE = 2'b11
	} prio_mode_type;

endpackage

//--- rtl/acl_action_store.sv
// per-port action entries with registered read ports
// assumes index 0..4 for ports 1..5; other indexes read as zero
`timescale 1ns/1ps
module acl_action_store (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       wr_hi,
	input  wire logic       wr_lo,
	input  wire logic [2:0] wr_idx,
	input  wire logic [8:0] wr_data,
	input  wire logic [2:0] sw_idx,
	output logic      [8:0] sw_q,
	input  wire logic [2:0] fr_idx,
	output logic      [8:0] fr_q
);
	logic [8:0] ent_r   [acl_action_pkg::NUM_PORTS];
	logic [8:0] ent_nxt [acl_action_pkg::NUM_PORTS];
	logic [8:0] sw_q_nxt;
	logic [8:0] fr_q_nxt;

	genvar g;
	generate
		for (g = 0; g < acl_action_pkg::NUM_PORTS; g++) begin : g_ent
			always_comb begin
				ent_nxt[g] = ent_r[g];
				if (wr_hi && wr_idx == 3'(g))
					ent_nxt[g][8:1] = wr_data[8:1];
				if (wr_lo && wr_idx == 3'(g))
					ent_nxt[g][0] = wr_data[0];
			end
			always_ff @(posedge clk) begin
				if (!rst_b)
					ent_r[g] <= acl_action_pkg::ENTRY_RESET;
				else
					ent_r[g] <= ent_nxt[g];
			end
		end
	endgenerate

	always_comb begin
		sw_q_nxt = acl_action_pkg::ENTRY_RESET;
		fr_q_nxt = acl_action_pkg::ENTRY_RESET;
		if (sw_idx < 3'(acl_action_pkg::NUM_PORTS))
			sw_q_nxt = ent_r[sw_idx];
		if (fr_idx < 3'(acl_action_pkg::NUM_PORTS))
			fr_q_nxt = ent_r[fr_idx];
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sw_q <= acl_action_pkg::ENTRY_RESET;
			fr_q <= acl_action_pkg::ENTRY_RESET;
		end else begin
			sw_q <= sw_q_nxt;
			fr_q <= fr_q_nxt;
		end
	end
endmodule // acl_action_store

//--- rtl/acl_priority_action_fields.sv
// indirect access to per-port priority/remark action bytes, and the
// per-frame priority and vlan priority decision that they steer
// assumes byte register port and frame inputs synchronous to clk
//
// Operation
// - Offset 0x0a makes the data register reach the port's priority byte.
// - Mode 00 keeps the classified priority of a tagged frame.
// - Mode 01 uses the action priority only if above the classified one.
// - Mode 10 uses the action priority only if below the classified one.
// - Mode 11 always substitutes the action priority.
// - The action priority sits at bits 5..3, resets to zero, acts per mode.
// - With remark enable at bit 2 clear the vlan priority passes unchanged.
// - With remark enable set the remark priority replaces the vlan priority.
// - Remark priority bits 2..1 sit in 0x0a[1:0] and bit 0 in 0x0b[7].
`timescale 1ns/1ps
module acl_priority_action_fields (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	input  wire logic       frame_valid,
	input  wire logic [3:0] frame_port,
	input  wire logic       frame_match,
	input  wire logic       frame_tagged,
	input  wire logic [2:0] frame_pri,
	input  wire logic [2:0] frame_vlan_pri,
	output logic            res_valid,
	output logic      [2:0] res_pri,
	output logic      [2:0] res_vlan_pri,
	output logic            res_remarked
);
	logic [7:0] ctrl_r,  ctrl_nxt;
	logic [7:0] offs_r,  offs_nxt;
	logic       rd_p1_r, rd_p1_nxt;
	logic [7:0] rd_addr_r, rd_addr_nxt;
	logic [7:0] rdata_nxt;
	logic       rvalid_nxt;
	logic       sel_ok;
	logic [2:0] tbl_sel;
	logic [3:0] port_sel;
	logic       off_pri;
	logic       off_map;
	logic [2:0] sel_idx;
	logic       wr_hi;
	logic       wr_lo;
	logic [8:0] wr_data;
	logic [8:0] sw_q;
	logic [8:0] fr_q;
	logic [2:0] fr_idx;
	logic       f1_valid_r,  f1_valid_nxt;
	logic       f1_act_r,    f1_act_nxt;
	logic       f1_tagged_r, f1_tagged_nxt;
	logic [2:0] f1_pri_r,    f1_pri_nxt;
	logic [2:0] f1_vlan_r,   f1_vlan_nxt;
	logic       res_valid_nxt;
	logic [2:0] res_pri_nxt;
	logic [2:0] res_vlan_nxt;
	logic       res_remarked_nxt;
	acl_action_pkg::prio_mode_type priority_select_mode;
	logic [2:0] action_pri;
	logic       remark_enable;
	logic [1:0] remark_priority_high;
	logic       remark_priority_low;

	// selection decode
	always_comb begin
		tbl_sel  = ctrl_r[acl_action_pkg::TBL_SEL_MSB:
			acl_action_pkg::TBL_SEL_LSB];
		port_sel = ctrl_r[acl_action_pkg::PORT_SEL_MSB:
			acl_action_pkg::PORT_SEL_LSB];
		off_pri  = offs_r == acl_action_pkg::OFF_PRI_ACTION;
		off_map  = offs_r == acl_action_pkg::OFF_REMARK_MAP;
		sel_ok   = tbl_sel == acl_action_pkg::TBL_ACL &&
			port_sel >= acl_action_pkg::PORT_FIRST &&
			port_sel <= acl_action_pkg::PORT_LAST;
		sel_idx  = 3'(port_sel - acl_action_pkg::PORT_FIRST);
		wr_hi    = reg_wr && reg_addr == acl_action_pkg::ADDR_IND_DATA &&
			sel_ok && off_pri;
		wr_lo    = reg_wr && reg_addr == acl_action_pkg::ADDR_IND_DATA &&
			sel_ok && off_map;
		wr_data = {reg_wdata, reg_wdata[acl_action_pkg::RP_LO_BIT]};
		fr_idx = 3'(frame_port - acl_action_pkg::PORT_FIRST);
	end

	acl_action_store u_store (
		.clk     (clk),
		.rst_b   (rst_b),
		.wr_hi   (wr_hi),
		.wr_lo   (wr_lo),
		.wr_idx  (sel_idx),
		.wr_data (wr_data),
		.sw_idx  (sel_idx),
		.sw_q    (sw_q),
		.fr_idx  (fr_idx),
		.fr_q    (fr_q)
	);

	// register port: control, offset and two-stage read
	always_comb begin
		ctrl_nxt    = ctrl_r;
		offs_nxt    = offs_r;
		rd_p1_nxt   = reg_rd;
		rd_addr_nxt = reg_rd ? reg_addr : rd_addr_r;
		if (reg_wr && reg_addr == acl_action_pkg::ADDR_IND_CTRL)
			ctrl_nxt = reg_wdata;
		if (reg_wr && reg_addr == acl_action_pkg::ADDR_IND_OFFS)
			offs_nxt = reg_wdata;
		rvalid_nxt = rd_p1_r;
		rdata_nxt  = reg_rdata;
		if (rd_p1_r) begin
			rdata_nxt = 8'h00;
			case (rd_addr_r)
				acl_action_pkg::ADDR_IND_CTRL: rdata_nxt = ctrl_r;
				acl_action_pkg::ADDR_IND_OFFS: rdata_nxt = offs_r;
				acl_action_pkg::ADDR_IND_DATA: begin
					if (sel_ok && off_pri)
						rdata_nxt = sw_q[8:1];
					else if (sel_ok && off_map)
						rdata_nxt = {sw_q[0], 7'h00};
				end
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r     <= acl_action_pkg::CTRL_RESET;
			offs_r     <= acl_action_pkg::OFFS_RESET;
			rd_p1_r    <= 1'b0;
			rd_addr_r  <= 8'h00;
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			ctrl_r     <= ctrl_nxt;
			offs_r     <= offs_nxt;
			rd_p1_r    <= rd_p1_nxt;
			rd_addr_r  <= rd_addr_nxt;
			reg_rdata  <= rdata_nxt;
			reg_rvalid <= rvalid_nxt;
		end
	end

	// frame pipeline: stage 1 fetches the entry, stage 2 decides
	always_comb begin
		priority_select_mode = acl_action_pkg::prio_mode_type'(fr_q[8:7]);
		action_pri           = fr_q[6:4];
		remark_enable        = fr_q[3];
		remark_priority_high = fr_q[2:1];
		remark_priority_low  = fr_q[0];
		f1_valid_nxt  = frame_valid;
		f1_act_nxt    = frame_valid && frame_match &&
			frame_port >= acl_action_pkg::PORT_FIRST &&
			frame_port <= acl_action_pkg::PORT_LAST;
		f1_tagged_nxt = frame_tagged;
		f1_pri_nxt    = frame_pri;
		f1_vlan_nxt   = frame_vlan_pri;
		res_valid_nxt    = f1_valid_r;
		res_pri_nxt      = f1_pri_r;
		res_vlan_nxt     = f1_vlan_r;
		res_remarked_nxt = 1'b0;
		if (f1_act_r && f1_tagged_r) begin
			case (priority_select_mode)
				acl_action_pkg::MODE_NONE:    res_pri_nxt = f1_pri_r;
				acl_action_pkg::MODE_GREATER:
					if (action_pri > f1_pri_r) res_pri_nxt = action_pri;
				acl_action_pkg::MODE_SMALLER:
					if (action_pri < f1_pri_r) res_pri_nxt = action_pri;
				acl_action_pkg::MODE_REPLACE: res_pri_nxt = action_pri;
				default:                      res_pri_nxt = f1_pri_r;
			endcase
			if (remark_enable) begin
				res_vlan_nxt = {remark_priority_high, remark_priority_low};
				res_remarked_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			f1_valid_r   <= 1'b0;
			f1_act_r     <= 1'b0;
			f1_tagged_r  <= 1'b0;
			f1_pri_r     <= 3'h0;
			f1_vlan_r    <= 3'h0;
			res_valid    <= 1'b0;
			res_pri      <= 3'h0;
			res_vlan_pri <= 3'h0;
			res_remarked <= 1'b0;
		end else begin
			f1_valid_r   <= f1_valid_nxt;
			f1_act_r     <= f1_act_nxt;
			f1_tagged_r  <= f1_tagged_nxt;
			f1_pri_r     <= f1_pri_nxt;
			f1_vlan_r    <= f1_vlan_nxt;
			res_valid    <= res_valid_nxt;
			res_pri      <= res_pri_nxt;
			res_vlan_pri <= res_vlan_nxt;
			res_remarked <= res_remarked_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic f1_on;
	assign f1_on = f1_act_r && f1_tagged_r;

	a_read_latency: assert property (
		reg_rd |-> ##2 reg_rvalid)
		else $error("read answer not two cycles after request");
	a_read_quiet: assert property (
		!reg_rd |-> ##2 !reg_rvalid)
		else $error("read answer without a request");
	a_rdata_hold: assert property (
		!reg_rd |-> ##2 $stable(reg_rdata))
		else $error("read data changed without an answer");
	a_bad_select: assert property (
		(reg_rd && reg_addr == acl_action_pkg::ADDR_IND_DATA) ##1 !sel_ok
		|-> ##1 reg_rdata == 8'h00)
		else $error("unselected data read not zero");
	a_pri_byte_back: assert property (
		(wr_hi && !reg_rd) ##1 (reg_rd && !reg_wr &&
		reg_addr == acl_action_pkg::ADDR_IND_DATA) |-> ##2
		reg_rdata == $past(reg_wdata, 3))
		else $error("priority action byte readback wrong");
	a_remark_low_back: assert property (
		(wr_lo && !reg_rd) ##1 (reg_rd && !reg_wr &&
		reg_addr == acl_action_pkg::ADDR_IND_DATA) |-> ##2
		reg_rdata == {$past(reg_wdata[7], 3), 7'h00})
		else $error("remark low bit readback wrong");
	a_mode_none: assert property (
		f1_on && priority_select_mode == acl_action_pkg::MODE_NONE |=>
		res_pri == $past(f1_pri_r))
		else $error("mode none altered priority");
	a_mode_greater: assert property (
		f1_on && priority_select_mode == acl_action_pkg::MODE_GREATER |=>
		res_pri == (($past(action_pri) > $past(f1_pri_r)) ?
		$past(action_pri) : $past(f1_pri_r)))
		else $error("mode greater wrong priority");
	a_mode_smaller: assert property (
		f1_on && priority_select_mode == acl_action_pkg::MODE_SMALLER |=>
		res_pri == (($past(action_pri) < $past(f1_pri_r)) ?
		$past(action_pri) : $past(f1_pri_r)))
		else $error("mode smaller wrong priority");
	a_mode_replace: assert property (
		f1_on && priority_select_mode == acl_action_pkg::MODE_REPLACE |=>
		res_pri == $past(action_pri))
		else $error("mode replace wrong priority");
	a_remark_off: assert property (
		frame_valid ##1 !remark_enable |=>
		res_vlan_pri == $past(frame_vlan_pri, 2) && !res_remarked)
		else $error("vlan priority changed without remark");
	a_remark_on: assert property (
		f1_on && remark_enable |=> res_remarked &&
		res_vlan_pri == {$past(remark_priority_high),
		$past(remark_priority_low)})
		else $error("remark priority not applied");
	a_nomatch_keep: assert property (
		frame_valid && !frame_match |-> ##2 res_valid &&
		res_pri == $past(frame_pri, 2) &&
		res_vlan_pri == $past(frame_vlan_pri, 2) && !res_remarked)
		else $error("unmatched frame was changed");
	a_untagged_keep: assert property (
		frame_valid && !frame_tagged |-> ##2 res_valid &&
		res_pri == $past(frame_pri, 2) &&
		res_vlan_pri == $past(frame_vlan_pri, 2) && !res_remarked)
		else $error("untagged frame was changed");
	a_bad_port: assert property (
		frame_valid && (frame_port < acl_action_pkg::PORT_FIRST ||
		frame_port > acl_action_pkg::PORT_LAST) |-> ##2 !res_remarked &&
		res_pri == $past(frame_pri, 2))
		else $error("frame on unknown port was changed");
	a_res_latency: assert property (
		frame_valid |-> ##2 res_valid)
		else $error("frame result not two cycles after request");
	a_res_quiet: assert property (
		!frame_valid |-> ##2 !res_valid)
		else $error("frame result without a request");
	a_reset_pri: assert property (
		$rose(rst_b) |-> u_store.ent_r[0][6:4] == 3'h0 &&
		u_store.ent_r[1][6:4] == 3'h0 && u_store.ent_r[2][6:4] == 3'h0 &&
		u_store.ent_r[3][6:4] == 3'h0 && u_store.ent_r[4][6:4] == 3'h0 &&
		!reg_rvalid && !res_valid)
		else $error("action priority not zero after reset");

	c_replace: cover property (f1_on &&
		priority_select_mode == acl_action_pkg::MODE_REPLACE);
	c_greater_hit: cover property (f1_on &&
		priority_select_mode == acl_action_pkg::MODE_GREATER &&
		action_pri > f1_pri_r);
	c_smaller_hit: cover property (f1_on &&
		priority_select_mode == acl_action_pkg::MODE_SMALLER &&
		action_pri < f1_pri_r);
	c_remark: cover property (res_remarked);
	c_readback: cover property (reg_rvalid && rd_addr_r ==
		acl_action_pkg::ADDR_IND_DATA && reg_rdata != 8'h00);
endmodule // acl_priority_action_fields

//--- testbench/acl_priority_action_fields_test.sv
// self-checking bench for the acl priority and remark action bytes
// assumes acl_action_pkg is compiled first; bench drives all ports
`timescale 1ns/1ps
module acl_priority_action_fields_test;
	logic       clk, rst_b, reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       frame_valid, frame_match, frame_tagged;
	logic [3:0] frame_port;
	logic [2:0] frame_pri, frame_vlan_pri, res_pri, res_vlan_pri;
	logic       res_valid, res_remarked;
	logic [7:0] ctrl_m, offs_m;
	logic [7:0] a_m [1:5];
	logic       b_m [1:5];
	int         error_cnt, n_compared;

	acl_priority_action_fields dut (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.frame_valid(frame_valid), .frame_port(frame_port),
		.frame_match(frame_match), .frame_tagged(frame_tagged),
		.frame_pri(frame_pri), .frame_vlan_pri(frame_vlan_pri),
		.res_valid(res_valid), .res_pri(res_pri),
		.res_vlan_pri(res_vlan_pri), .res_remarked(res_remarked));

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic bit sel_ok();
		return ctrl_m[7:5] == acl_action_pkg::TBL_ACL &&
			ctrl_m[3:0] >= acl_action_pkg::PORT_FIRST &&
			ctrl_m[3:0] <= acl_action_pkg::PORT_LAST;
	endfunction

	function automatic logic [7:0] exp_rd(input logic [7:0] ad);
		if (ad == acl_action_pkg::ADDR_IND_CTRL) return ctrl_m;
		if (ad == acl_action_pkg::ADDR_IND_OFFS) return offs_m;
		if (ad != acl_action_pkg::ADDR_IND_DATA || !sel_ok()) return 8'h00;
		if (offs_m == acl_action_pkg::OFF_PRI_ACTION)
			return a_m[ctrl_m[2:0]];
		if (offs_m == acl_action_pkg::OFF_REMARK_MAP)
			return {b_m[ctrl_m[2:0]], 7'h00};
		return 8'h00;
	endfunction

	// fixed answer latency of two cycles after the taking edge
	task automatic wait_out(input bit res);
		int i;
		for (i = 2; i < 6; i++) begin
			@(posedge clk);
			#1;
			if (res ? res_valid : reg_rvalid) break;
		end
		chk(8'(i), 8'h02);
		if (i == 6) close_out();
	endtask

	// mirror of a register write in the bench's model
	function automatic void model_wr(input logic [7:0] ad,
		input logic [7:0] d);
		if (ad == acl_action_pkg::ADDR_IND_CTRL) ctrl_m = d;
		else if (ad == acl_action_pkg::ADDR_IND_OFFS) offs_m = d;
		else if (ad == acl_action_pkg::ADDR_IND_DATA && sel_ok()) begin
			if (offs_m == acl_action_pkg::OFF_PRI_ACTION)
				a_m[ctrl_m[2:0]] = d;
			if (offs_m == acl_action_pkg::OFF_REMARK_MAP)
				b_m[ctrl_m[2:0]] = d[7];
		end
	endfunction

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(negedge clk);
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		model_wr(ad, d);
	endtask

	task automatic rd(input logic [7:0] ad);
		logic [7:0] e;
		e = exp_rd(ad);
		@(negedge clk);
		reg_addr = ad;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		wait_out(1'b0);
		chk(reg_rdata, e);
	endtask

	// data write, then a read of it in the very next cycle
	task automatic wr_rd(input logic [7:0] d);
		logic [7:0] e;
		@(negedge clk);
		reg_addr = acl_action_pkg::ADDR_IND_DATA;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		model_wr(acl_action_pkg::ADDR_IND_DATA, d);
		e = exp_rd(acl_action_pkg::ADDR_IND_DATA);
		@(negedge clk);
		reg_rd = 1'b0;
		wait_out(1'b0);
		chk(reg_rdata, e);
	endtask

	task automatic frm(input logic [3:0] p, input logic m, input logic t,
		input logic [2:0] pr, input logic [2:0] vp);
		logic [6:0] e;
		logic [7:0] a;
		e = {pr, vp, 1'b0};
		if (m && t && p >= 4'h1 && p <= 4'h5) begin
			a = a_m[p[2:0]];
			case (a[7:6])
			acl_action_pkg::MODE_GREATER: if (a[5:3] > pr) e[6:4] = a[5:3];
			acl_action_pkg::MODE_SMALLER: if (a[5:3] < pr) e[6:4] = a[5:3];
			acl_action_pkg::MODE_REPLACE: e[6:4] = a[5:3];
			default: e[6:4] = pr;
			endcase
			if (a[2]) e[3:0] = {a[1:0], b_m[p[2:0]], 1'b1};
		end
		@(negedge clk);
		{frame_port, frame_match, frame_tagged} = {p, m, t};
		{frame_pri, frame_vlan_pri, frame_valid} = {pr, vp, 1'b1};
		@(negedge clk);
		frame_valid = 1'b0;
		wait_out(1'b1);
		chk(8'(res_pri), 8'(e[6:4]));
		chk(8'({res_vlan_pri, res_remarked}), 8'(e[3:0]));
	endtask

	task automatic do_reset();
		@(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		ctrl_m = 8'h00;
		offs_m = 8'h00;
		for (int p = 1; p <= 5; p++) begin
			a_m[p] = 8'h00;
			b_m[p] = 1'b0;
		end
	endtask

	// every port's priority action byte reads zero after reset, then both bytes are written and read back
	task automatic sweep_zero();
		for (int p = 1; p <= 5; p++) begin
			wr(acl_action_pkg::ADDR_IND_CTRL, {3'b010, 1'b0, 4'(p)});
			wr(acl_action_pkg::ADDR_IND_OFFS, acl_action_pkg::OFF_PRI_ACTION);
			rd(acl_action_pkg::ADDR_IND_DATA);
			wr_rd(8'($urandom));
			wr(acl_action_pkg::ADDR_IND_OFFS, acl_action_pkg::OFF_REMARK_MAP);
			wr_rd(8'($urandom));
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		logic [7:0] ad;
		{rst_b, reg_wr, reg_rd, frame_valid, frame_match} = '0;
		{reg_addr, reg_wdata, frame_port, frame_tagged} = '0;
		{frame_pri, frame_vlan_pri} = '0;
		error_cnt = 0;
		n_compared = 0;
		void'($urandom(32'h18efec99));
		do_reset();
		rd(acl_action_pkg::ADDR_IND_CTRL);
		rd(acl_action_pkg::ADDR_IND_DATA);
		sweep_zero();
		rd(8'h55);
		for (int k = 0; k < 400; k++) begin
			case ($urandom % 7)
			0: wr(acl_action_pkg::ADDR_IND_CTRL, {($urandom % 4 == 0) ?
				3'($urandom) : 3'b010, 1'b0, 4'($urandom % 7)});
			1: wr(acl_action_pkg::ADDR_IND_OFFS, ($urandom % 4 == 0) ?
				8'($urandom) : 8'h0a + 8'($urandom % 2));
			2: wr(acl_action_pkg::ADDR_IND_DATA, 8'($urandom));
			3: begin
				ad = ($urandom % 4 == 0) ? 8'($urandom) : 8'ha0;
				rd(ad);
			end
			5: wr_rd(8'($urandom));
			default: frm(4'($urandom % 8), ($urandom % 4) != 0,
				($urandom % 4) != 0, 3'($urandom), 3'($urandom));
			endcase
		end
		do_reset();
		sweep_zero();
		close_out();
	end
endmodule // acl_priority_action_fields_test
